// *** hdl/sar_adc_sequencer.sv ***
// Purpose: Control logic of an 8-bit, 12-channel successive-approximation converter
// Assumes: Comparator answer arrives on cmp_high, synchronous to clk
// Notes:   Register port: addr, wdata, wr, rd; read data valid the cycle after rd
// Overview of operation
// - Twelve pin channels, one 8-bit result
// - Conversion lasts sixteen converter clocks
// - Start on first converter edge after write
// - Rail inputs give ff and 00 codes
// - Continuous mode overwrites result every conversion
// - Single conversion otherwise; continuous cleared by reset
// - Done flag set, cleared by write/read/reset
// - Done flag reads zero when interrupts enabled
// - Interrupt request at end when enabled
// - Five-bit channel field, all ones powers off
// - Selected pin forced to converter input
// - Port writes do not affect selected pin
// - Selected pin reads zero or data latch
// - Runs in wait; request wakes processor
// - Stop aborts conversion; idle afterwards until the next control write
// - Code map to port B, D, references
// - Result register updated at each completion
// - Prescaler divides by 1,2,4,8 or 16
`include "sar_params.svh"
module sar_adc_sequencer #(
  parameter int NUM_CH = 12
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire sar_pkg::sar_bus_req_t bus_req,
  output logic [7:0]                 rdata,
  input  wire logic                  stop_mode,
  input  wire logic                  cmp_high,
  input  wire logic [NUM_CH-1:0]     pin_ddr,
  input  wire logic [NUM_CH-1:0]     pin_latch,
  input  wire logic [NUM_CH-1:0]     pin_level,
  output logic [NUM_CH-1:0]          pin_read,
  output logic [NUM_CH-1:0]          pin_drive_en,
  output logic [7:0]                 dac_code,
  output sar_pkg::sar_mux_t          mux_sel,
  output logic                       conv_irq,
  output logic                       busy
);
  import sar_pkg::*;

  logic [4:0]  channel_select_reg;
  logic        conv_irq_enable_reg;
  logic        continuous_conv_enable_reg;
  logic [2:0]  prescale_select_reg;
  logic        done_reg;
  logic        irq_reg;
  logic [7:0]  result_reg;
  logic [7:0]  sar_reg;
  logic [4:0]  step_reg;
  logic [7:0]  rdata_reg;
  sar_state_t  state_reg;
  logic        conv_tick;
  logic        ctrl_wr;
  logic        data_rd;
  logic        conv_end;
  logic        powered;
  logic [3:0]  bit_idx;

  // Map a channel code to its shared pin position, or all-ones if none
  function automatic logic [3:0] pin_of(input logic [4:0] code);
    logic [3:0] r;
    r = 4'hf;
    if (code < `SAR_CH_FIRST_PORTD) begin
      r = code[3:0];
    end else if (code <= `SAR_CH_LAST_PIN) begin
      r = code[3:0];
    end
    return r;
  endfunction

  assign ctrl_wr = bus_req.wr && (bus_req.addr == `SAR_OFF_CTRL);
  assign data_rd = bus_req.rd && (bus_req.addr == `SAR_OFF_DATA);
  assign powered = (channel_select_reg != `SAR_CH_OFF_CODE);
  assign conv_end = (state_reg == SAR_CONV) && conv_tick
                    && (step_reg == `SAR_CONV_CYCLES - 5'h1);

  sar_clk_div u_div (
    .clk             (clk),
    .rst             (rst),
    .run             (powered && !stop_mode),
    .prescale_select (prescale_select_reg),
    .conv_tick       (conv_tick)
  );

  // Control register fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_select_reg         <= `SAR_CH_OFF_CODE;
      conv_irq_enable_reg        <= 1'b0;
      continuous_conv_enable_reg <= 1'b0;
    end else if (ctrl_wr) begin
      channel_select_reg         <= bus_req.wdata[`SAR_CH_W-1:0];
      conv_irq_enable_reg        <= bus_req.wdata[`SAR_BIT_IRQ_EN];
      continuous_conv_enable_reg <= bus_req.wdata[`SAR_BIT_CONT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale_select_reg <= `SAR_PRESC_RESET;
    end else if (bus_req.wr && bus_req.addr == `SAR_OFF_CLKSEL) begin
      prescale_select_reg <= bus_req.wdata[7:`SAR_BIT_PRESC_LSB];
    end
  end

  // Sequencer: write arms, next converter edge starts, sixteen edges convert
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SAR_IDLE;
      step_reg  <= 5'h0;
    end else if (stop_mode) begin
      state_reg <= SAR_IDLE;
      step_reg  <= 5'h0;
    end else if (ctrl_wr) begin
      // Checked before power so a write that leaves the off code still arms
      state_reg <= SAR_WAIT;
      step_reg  <= 5'h0;
    end else if (!powered) begin
      state_reg <= SAR_IDLE;
      step_reg  <= 5'h0;
    end else begin
      case (state_reg)
        SAR_WAIT: begin
          if (conv_tick) begin
            state_reg <= SAR_CONV;
            step_reg  <= 5'h0;
          end
        end
        SAR_CONV: begin
          if (conv_tick) begin
            if (conv_end) begin
              step_reg  <= 5'h0;
              state_reg <= continuous_conv_enable_reg ? SAR_CONV : SAR_IDLE;
            end else begin
              step_reg <= step_reg + 5'h1;
            end
          end
        end
        default: begin
          state_reg <= SAR_IDLE;
        end
      endcase
    end
  end

  // Successive approximation: steps 0..7 decide bits 7..0, rest settle
  assign bit_idx = 4'(3'h7 - step_reg[2:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sar_reg <= 8'h80;
    end else if (state_reg != SAR_CONV) begin
      sar_reg <= 8'h80;
    end else if (conv_end) begin
      sar_reg <= 8'h80;
    end else if (conv_tick && step_reg < 5'h8) begin
      if (!cmp_high) begin
        sar_reg[bit_idx[2:0]] <= 1'b0;
      end
      if (step_reg != 5'h7) begin
        sar_reg[bit_idx[2:0] - 3'h1] <= 1'b1;
      end
    end
  end

  assign dac_code = sar_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg <= `SAR_RESULT_ZERO;
    end else if (conv_end) begin
      if (channel_select_reg == `SAR_CH_VDD_CODE) begin
        result_reg <= `SAR_RESULT_FULL;
      end else if (channel_select_reg == `SAR_CH_VSS_CODE) begin
        result_reg <= `SAR_RESULT_ZERO;
      end else begin
        result_reg <= sar_reg;
      end
    end
  end

  // Completion flag and interrupt: set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (conv_end && !conv_irq_enable_reg) begin
      done_reg <= 1'b1;
    end else if (ctrl_wr || data_rd) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (conv_end && conv_irq_enable_reg) begin
      irq_reg <= 1'b1;
    end else if (ctrl_wr || data_rd || !conv_irq_enable_reg) begin
      irq_reg <= 1'b0;
    end
  end

  assign conv_irq = irq_reg;
  assign busy     = (state_reg != SAR_IDLE);

  // Read data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (bus_req.rd) begin
      if (bus_req.addr == `SAR_OFF_CTRL) begin
        rdata_reg <= {done_reg && !conv_irq_enable_reg, conv_irq_enable_reg,
                      continuous_conv_enable_reg, channel_select_reg};
      end else if (bus_req.addr == `SAR_OFF_DATA) begin
        rdata_reg <= result_reg;
      end else if (bus_req.addr == `SAR_OFF_CLKSEL) begin
        rdata_reg <= {prescale_select_reg, 5'h00};
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign rdata = rdata_reg;

  // Pin takeover for the selected channel
  always_comb begin
    logic [3:0] p;
    p = pin_of(channel_select_reg);
    for (int i = 0; i < NUM_CH; i++) begin
      if (p == 4'(i)) begin
        pin_drive_en[i] = 1'b0;
        pin_read[i]     = pin_ddr[i] ? pin_latch[i] : 1'b0;
      end else begin
        pin_drive_en[i] = pin_ddr[i];
        pin_read[i]     = pin_ddr[i] ? pin_latch[i] : pin_level[i];
      end
    end
  end

  always_comb begin
    logic [3:0] p;
    p = pin_of(channel_select_reg);
    mux_sel.port_override = '0;
    if (p != 4'hf) begin
      mux_sel.port_override[p] = 1'b1;
    end
    mux_sel.use_vdd_ref = (channel_select_reg == `SAR_CH_VDD_CODE);
    mux_sel.use_vss_ref = (channel_select_reg == `SAR_CH_VSS_CODE);
    mux_sel.powered     = powered && !stop_mode;
  end

  a_done_masked: assert property (@(posedge clk) disable iff (rst)
    conv_irq_enable_reg |-> !(rdata_reg[7] && $past(bus_req.rd)
    && $past(bus_req.addr) == `SAR_OFF_CTRL && $past(conv_irq_enable_reg)))
    else $error("done flag visible with interrupts on");
  a_irq_on_end: assert property (@(posedge clk) disable iff (rst)
    conv_end && conv_irq_enable_reg |=> irq_reg)
    else $error("irq not raised at end");
  a_irq_held: assert property (@(posedge clk) disable iff (rst)
    irq_reg && !ctrl_wr && !data_rd && conv_irq_enable_reg |=> irq_reg)
    else $error("irq dropped without clear");
  a_done_set: assert property (@(posedge clk) disable iff (rst)
    conv_end && !conv_irq_enable_reg |=> done_reg)
    else $error("done flag not set");
  a_done_clear: assert property (@(posedge clk) disable iff (rst)
    (ctrl_wr || data_rd) && !conv_end |=> !done_reg)
    else $error("done flag not cleared");
  a_start_edge: assert property (@(posedge clk) disable iff (rst)
    state_reg == SAR_WAIT && conv_tick && !ctrl_wr && powered && !stop_mode
    |=> state_reg == SAR_CONV && step_reg == 5'h0)
    else $error("start not on first converter edge");
  a_single_stop: assert property (@(posedge clk) disable iff (rst)
    conv_end && !continuous_conv_enable_reg && !ctrl_wr |=> state_reg == SAR_IDLE)
    else $error("single mode did not stop");
  a_stop_abort: assert property (@(posedge clk) disable iff (rst)
    stop_mode |=> state_reg == SAR_IDLE)
    else $error("stop did not abort");
  a_result_load: assert property (@(posedge clk) disable iff (rst)
    conv_end && channel_select_reg < 5'h0c |=> result_reg == $past(sar_reg))
    else $error("result not stored");
  a_pin_taken: assert property (@(posedge clk) disable iff (rst)
    channel_select_reg < 5'h0c |-> !pin_drive_en[pin_of(channel_select_reg)])
    else $error("selected pin still driven");

  c_single: cover property (@(posedge clk) conv_end && !continuous_conv_enable_reg);
  c_cont: cover property (@(posedge clk) conv_end && continuous_conv_enable_reg);
  c_irq: cover property (@(posedge clk) irq_reg && data_rd);
  c_abort: cover property (@(posedge clk) state_reg == SAR_CONV && stop_mode);
endmodule // sar_adc_sequencer

// *** shared/sar_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the converter sequencer
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Included by the design modules and the bench
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define SAR_ADDR_W          8
`define SAR_OFF_CTRL        8'h3c
`define SAR_OFF_DATA        8'h3d
`define SAR_OFF_CLKSEL      8'h3e
`define SAR_BIT_DONE        7
`define SAR_BIT_IRQ_EN      6
`define SAR_BIT_CONT        5
`define SAR_BIT_PRESC_LSB   5
`define SAR_CH_W            5
`define SAR_CH_OFF_CODE     5'h1f
`define SAR_CH_VDD_CODE     5'h1d
`define SAR_CH_VSS_CODE     5'h1e
`define SAR_CH_LAST_PIN     5'h0b
`define SAR_CH_FIRST_PORTD  5'h08
`define SAR_PRESC_RESET     3'h0
`define SAR_CONV_CYCLES     5'h10
`define SAR_RESULT_FULL     8'hff
`define SAR_RESULT_ZERO     8'h00
`endif

// *** shared/sar_pkg.sv ***
// Purpose: Types shared by the converter sequencer files
// Assumes: Constants come from sar_params.svh
// Notes:   States are Gray coded along idle, wait edge, converting
package sar_pkg;
  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_WAIT = 2'b01,
    SAR_CONV = 2'b11
  } sar_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sar_bus_req_t;

  typedef struct packed {
    logic [11:0] port_override;
    logic        use_vdd_ref;
    logic        use_vss_ref;
    logic        powered;
  } sar_mux_t;
endpackage

// *** hdl/sar_clk_div.sv ***
// Purpose: Converter clock enable from the prescaler select
// Assumes: One system clock; output is a one-cycle enable
// Notes:   Ratio 1,2,4,8 for codes 0..3, 16 when top bit set
`include "sar_params.svh"
module sar_clk_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] prescale_select,
  output logic            conv_tick
);
  import sar_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] limit;

  always_comb begin
    if (prescale_select[2]) begin
      limit = 4'hf;
    end else begin
      limit = 4'((5'h1 << prescale_select[1:0]) - 5'h1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
    end else if (!run || cnt_reg >= limit) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  assign conv_tick = run && (cnt_reg >= limit);
endmodule // sar_clk_div

// *** test/sar_afe_model.sv ***
// Purpose: Analog front end behind the sequencer: comparator on the selected input
// Assumes: vin is the selected pin level expressed as a result code
// Notes:   Unpowered, the comparator output wanders with the trial code
module sar_afe_model (
  input  wire logic [7:0]        vin,
  input  wire logic [7:0]        dac_code,
  input  wire sar_pkg::sar_mux_t mux_sel,
  output logic                   cmp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  import sar_pkg::*;
  always_comb begin
    if (!mux_sel.powered) cmp_high = ~dac_code[0];
    else if (mux_sel.use_vdd_ref) cmp_high = 1'b1;
    else if (mux_sel.use_vss_ref) cmp_high = 1'b0;
    else cmp_high = (vin >= dac_code);
  end
endmodule // sar_afe_model

// *** test/tb.sv ***
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Register port with read data the cycle after rd
// Notes:   Analog side is sar_afe_model
`include "sar_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_pkg::*;
  localparam logic [7:0] off_ctl = `SAR_OFF_CTRL;
  localparam logic [7:0] off_dat = `SAR_OFF_DATA;
  localparam logic [7:0] off_clk = `SAR_OFF_CLKSEL;
  logic         clk = 0, rst = 1, stop_mode = 0, cmp_high, conv_irq, busy;
  sar_bus_req_t req = '0;
  logic [7:0]   rdata, dac_code, d, vin = 8'h5a;
  logic [11:0]  pin_ddr = '0, pin_latch = '0, pin_level = '0, pin_read, pin_drive_en;
  sar_mux_t     mux_sel;
  int           fail_count = 0, comparisons = 0, n;

  always #4 clk = ~clk;

  sar_adc_sequencer u_sar_adc_sequencer (.clk(clk), .rst(rst), .bus_req(req), .rdata(rdata),
    .stop_mode(stop_mode), .cmp_high(cmp_high), .pin_ddr(pin_ddr), .pin_latch(pin_latch),
    .pin_level(pin_level), .pin_read(pin_read), .pin_drive_en(pin_drive_en),
    .dac_code(dac_code), .mux_sel(mux_sel), .conv_irq(conv_irq), .busy(busy));
  sar_afe_model u_sar_afe_model (.vin(vin), .dac_code(dac_code), .mux_sel(mux_sel),
    .cmp_high(cmp_high));

  task automatic chk(input string what, input logic [11:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, v);
    @(posedge clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Irq high when want_irq, else busy low; gives up after 600 cycles
  task automatic wait_for(input bit want_irq);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((want_irq ? conv_irq !== 1'b1 : busy !== 1'b0) && n < 600);
    if (n >= 600) begin
      $display("mismatch wait expected done seen timeout");
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic test_reset();
    rd(off_ctl, d);
    chk("ctrl after reset", 12'h01f, {4'h0, d});
    chk("busy after reset", 12'h000, {11'h0, busy | conv_irq});
    chk("trial code after reset", 12'h080, {4'h0, dac_code});
    rd(8'h50, d);
    chk("unmapped read", 12'h000, {4'h0, d});
    $display("test reset ended");
  endtask

  task automatic test_single();
    int div;
    wr(off_ctl, 8'h00);
    wait_for(0);
    for (int p = 0; p < 5; p++) begin
      div = p[2] ? 16 : (1 << p);
      vin = 8'h5a + 8'(p * 37);
      wr(off_clk, {p[2:0], 5'h00});
      wr(off_ctl, 8'h00);
      wait_for(0);
      chk("conversion span", 12'h001, {11'h0, n >= 16 * div && n <= 17 * div + 2});
      repeat (20) @(negedge clk);
      chk("single stops", 12'h000, {11'h0, busy});
      rd(off_ctl, d);
      chk("done set", 12'h080, {4'h0, d});
      rd(off_dat, d);
      chk("result", {4'h0, vin}, {4'h0, d});
      rd(off_ctl, d);
      chk("done cleared by data read", 12'h000, {4'h0, d});
    end
    $display("test single ended");
  endtask

  task automatic test_rails();
    vin = 8'h80;
    wr(off_ctl, 8'h1d);
    wait_for(0);
    rd(off_dat, d);
    chk("upper reference", 12'h0ff, {4'h0, d});
    wr(off_ctl, 8'h1e);
    wait_for(0);
    rd(off_dat, d);
    chk("lower reference", 12'h000, {4'h0, d});
    $display("test rails ended");
  endtask

  task automatic test_irq();
    vin = 8'h91;
    wr(off_ctl, 8'h41);
    wait_for(1);
    rd(off_ctl, d);
    chk("done masked", 12'h041, {4'h0, d});
    chk("irq held", 12'h001, {11'h0, conv_irq});
    rd(off_dat, d);
    chk("irq result", 12'h091, {4'h0, d});
    chk("irq cleared by read", 12'h000, {11'h0, conv_irq});
    wr(off_ctl, 8'h41);
    wait_for(1);
    wr(off_ctl, 8'h01);
    #1 chk("irq cleared by write", 12'h000, {11'h0, conv_irq});
    wait_for(0);
    rd(off_ctl, d);
    chk("done without irq", 12'h081, {4'h0, d});
    wr(off_ctl, 8'h01);
    rd(off_ctl, d);
    chk("done cleared by write", 12'h001, {4'h0, d});
    $display("test irq ended");
  endtask

  task automatic test_cont();
    vin = 8'h33;
    wr(off_clk, 8'h00);
    wr(off_ctl, 8'h22);
    repeat (40) @(negedge clk);
    vin = 8'hc4;
    repeat (40) @(negedge clk);
    rd(off_dat, d);
    chk("overwritten result", 12'h0c4, {4'h0, d});
    chk("still running", 12'h001, {11'h0, busy});
    @(posedge clk);
    pin_ddr <= 12'hfff;
    pin_latch <= 12'h0a5;
    @(negedge clk);
    chk("drive enables", 12'hffb, pin_drive_en);
    chk("override", 12'h004, mux_sel.port_override);
    chk("read latch", 12'h001, {11'h0, pin_read[2]});
    @(posedge clk);
    pin_ddr <= 12'hffb;
    pin_level <= 12'hfff;
    @(negedge clk);
    chk("read zero", 12'h000, {11'h0, pin_read[2]});
    chk("read others", 12'h0a1, pin_read);
    @(posedge clk);
    stop_mode <= 1'b1;
    repeat (3) @(negedge clk);
    chk("stop aborts", 12'h000, {11'h0, busy});
    @(posedge clk);
    stop_mode <= 1'b0;
    wr(off_ctl, 8'h08);
    @(negedge clk);
    chk("resume", 12'h001, {11'h0, busy});
    chk("port d pin", 12'h100, mux_sel.port_override);
    wr(off_ctl, 8'h1f);
    @(negedge clk);
    chk("powered off", 12'h000, {11'h0, mux_sel.powered});
    chk("port control back", pin_ddr, pin_drive_en);
    $display("test continuous ended");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_single();
    test_rails();
    test_irq();
    test_cont();
    report_and_stop();
  end
endmodule // tb
